/* File: hw/gsp_pkg.sv */
// Purpose: constants and helpers shared by the port and serial pin override block
// Assumes: apb register file with 32-bit data, one aligned word per register
// Notes: all offsets and field positions, the control and override select reset values and the bus clock count live here
package gsp_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LATCH = 8'h04;
  localparam logic [7:0] ADDR_OVR = 8'h08;

  // ==========================================================
  // widths and reset values
  localparam int PORT_W = 8;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] OVR_SEL_RST = 2'h0;

  // ==========================================================
  // override register fields
  localparam int OVR_SCLK_SEL = 3;
  localparam int OVR_SCLK_LVL = 2;
  localparam int OVR_TXD_SEL = 1;
  localparam int OVR_BRK_LVL = 0;
  localparam int OVR_RSVD_LO = 4;

  // ==========================================================
  // external bus clock: pclk divided down, one enable pulse per period
  localparam logic [1:0] BUS_DIV_LAST = 2'h3;

  // even bits: direction, 1 = output
  function automatic logic [7:0] dir_bits(input logic [15:0] ctrl);
    logic [7:0] d;
    d = 8'h00;
    for (int n = 0; n < PORT_W; n++) begin
      d[n] = ctrl[2*n];
    end
    return d;
  endfunction

  // odd bits: 0 = pull-up on, returned as enable
  function automatic logic [7:0] pull_en_bits(input logic [15:0] ctrl);
    logic [7:0] p;
    p = 8'h00;
    for (int n = 0; n < PORT_W; n++) begin
      p[n] = ~ctrl[2*n+1];
    end
    return p;
  endfunction

endpackage

/* File: hw/gsp_port_pins.sv */
// Purpose: drivers of the eight general-purpose port pins
// Assumes: control and latch values arrive from the register file
// Notes: outputs are registered, one pclk behind the registers
`timescale 1ns/1ps
module gsp_port_pins (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register values
  input wire logic [15:0] ctrl,
  input wire logic [7:0] latch,
  // pins
  output logic [7:0] port_o,
  output logic [7:0] port_oe,
  output logic [7:0] port_pu_en
);

  // ==========================================================
  // pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_oe <= 8'h00;
      port_o <= 8'h00;
      port_pu_en <= 8'hff;
    end else begin
      port_oe <= gsp_pkg::dir_bits(ctrl);
      port_o <= latch & gsp_pkg::dir_bits(ctrl);
      // pull-up follows its bit even on an output pin
      port_pu_en <= gsp_pkg::pull_en_bits(ctrl);
    end
  end

endmodule

/* File: hw/gsp_serial_pins.sv */
// Purpose: serial clock and transmit pin multiplexing with port override
// Assumes: the serial interface keeps its drivers off until programmed
// Notes: override wins over the serial interface on each pin
`timescale 1ns/1ps
module gsp_serial_pins (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // override register fields
  input wire logic sclk_port_drive_select,
  input wire logic sclk_port_level,
  input wire logic txd_port_drive_select,
  input wire logic break_port_level,
  // serial interface drive
  input wire logic sci_sck_o,
  input wire logic sci_sck_oe,
  input wire logic sci_txd_o,
  input wire logic sci_txd_oe,
  // pins
  output logic sck_o,
  output logic sck_oe,
  output logic txd_o,
  output logic txd_oe
);

  // ==========================================================
  // pin multiplexers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      txd_o <= 1'b0;
      txd_oe <= 1'b0;
    end else begin
      sck_oe <= sclk_port_drive_select | sci_sck_oe;
      sck_o <= sclk_port_drive_select ? sclk_port_level : sci_sck_o;
      txd_oe <= txd_port_drive_select | sci_txd_oe;
      txd_o <= txd_port_drive_select ? break_port_level : sci_txd_o;
    end
  end

endmodule

/* File: hw/gsp_port.sv */
// Purpose: register-controlled 8-bit port plus serial pin override, apb slave
// Assumes: pins synchronous to pclk; pclk 40 MHz; presetn is the power-on reset
// Notes: manual reset and standby do not touch any register here
`timescale 1ns/1ps
module gsp_port (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset kinds that must leave registers alone
  input wire logic manual_reset_n,
  input wire logic standby,
  // external bus master
  input wire logic bus_release_request,
  // port pins
  input wire logic [7:0] port_i,
  output logic [7:0] port_o,
  output logic [7:0] port_oe,
  output logic [7:0] port_pu_en,
  // serial pins
  input wire logic sck_i,
  input wire logic txd_i,
  input wire logic rxd_i,
  output logic sck_o,
  output logic sck_oe,
  output logic txd_o,
  output logic txd_oe,
  // serial interface side
  input wire logic sci_sck_o,
  input wire logic sci_sck_oe,
  input wire logic sci_txd_o,
  input wire logic sci_txd_oe,
  output logic [2:0] boot_mode_inputs
);

  // ==========================================================
  // registers
  logic [15:0] port_dir_pull_ctrl_r;
  logic [7:0] port_pin_latch_r;
  logic [1:0] ovr_sel_r;
  logic [1:0] ovr_lvl_r;
  logic [7:0] pin_sample_r;
  logic [1:0] bus_div_r;
  logic bus_clk_en;
  logic boot_armed_r;
  logic acc_first;
  logic wr_fire;
  logic [31:0] rdata_nxt;
  logic unmapped;

  assign acc_first = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign unmapped = (paddr != gsp_pkg::ADDR_CTRL) && (paddr != gsp_pkg::ADDR_LATCH) &&
                    (paddr != gsp_pkg::ADDR_OVR);
  assign bus_clk_en = (bus_div_r == gsp_pkg::BUS_DIV_LAST);

  // ==========================================================
  // apb handshake: one wait state, answer registered
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (paddr == gsp_pkg::ADDR_CTRL) begin
      rdata_nxt = {16'h0000, port_dir_pull_ctrl_r};
    end else if (paddr == gsp_pkg::ADDR_LATCH) begin
      rdata_nxt = {24'h00_0000, pin_sample_r};
    end else if (paddr == gsp_pkg::ADDR_OVR) begin
      // level bits show the pins, not the stored values
      rdata_nxt = {28'h000_0000, ovr_sel_r[1], sck_i, ovr_sel_r[0], rxd_i};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (acc_first) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= unmapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // control register, power-on reset only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_dir_pull_ctrl_r <= gsp_pkg::CTRL_RST;
    end else if (wr_fire && paddr == gsp_pkg::ADDR_CTRL) begin
      if (pstrb[0]) begin
        port_dir_pull_ctrl_r[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        port_dir_pull_ctrl_r[15:8] <= pwdata[15:8];
      end
    end
  end

  // ==========================================================
  // data latch: deliberately no reset of any kind
  always_ff @(posedge pclk) begin
    if (wr_fire && paddr == gsp_pkg::ADDR_LATCH && pstrb[0]) begin
      port_pin_latch_r <= pwdata[7:0];
    end
  end

  // ==========================================================
  // external bus clock and pin sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_div_r <= 2'h0;
    end else begin
      bus_div_r <= bus_div_r + 2'h1;
    end
  end

  // sample frozen while the bus is being released, value not trusted then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sample_r <= 8'h00;
    end else if (bus_clk_en && !bus_release_request) begin
      pin_sample_r <= port_i;
    end
  end

  // ==========================================================
  // serial pin override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_sel_r <= gsp_pkg::OVR_SEL_RST;
    end else if (wr_fire && paddr == gsp_pkg::ADDR_OVR && pstrb[0]) begin
      ovr_sel_r <= {pwdata[gsp_pkg::OVR_SCLK_SEL], pwdata[gsp_pkg::OVR_TXD_SEL]};
    end
  end

  // level bits power up undefined, hence no reset
  always_ff @(posedge pclk) begin
    if (wr_fire && paddr == gsp_pkg::ADDR_OVR && pstrb[0]) begin
      ovr_lvl_r <= {pwdata[gsp_pkg::OVR_SCLK_LVL], pwdata[gsp_pkg::OVR_BRK_LVL]};
    end
  end

  // ==========================================================
  // mode pins caught on the first edge after power-on release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_armed_r <= 1'b1;
      boot_mode_inputs <= 3'h0;
    end else if (boot_armed_r) begin
      boot_armed_r <= 1'b0;
      boot_mode_inputs <= {rxd_i, txd_i, sck_i};
    end
  end

  // ==========================================================
  // pin cells
  gsp_port_pins u_port_pins (
    .pclk(pclk),
    .presetn(presetn),
    .ctrl(port_dir_pull_ctrl_r),
    .latch(port_pin_latch_r),
    .port_o(port_o),
    .port_oe(port_oe),
    .port_pu_en(port_pu_en)
  );

  gsp_serial_pins u_serial_pins (
    .pclk(pclk),
    .presetn(presetn),
    .sclk_port_drive_select(ovr_sel_r[1]),
    .sclk_port_level(ovr_lvl_r[1]),
    .txd_port_drive_select(ovr_sel_r[0]),
    .break_port_level(ovr_lvl_r[0]),
    .sci_sck_o(sci_sck_o),
    .sci_sck_oe(sci_sck_oe),
    .sci_txd_o(sci_txd_o),
    .sci_txd_oe(sci_txd_oe),
    .sck_o(sck_o),
    .sck_oe(sck_oe),
    .txd_o(txd_o),
    .txd_oe(txd_oe)
  );

  // ==========================================================
  // assertions
  property p_dir_oe;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> port_oe == gsp_pkg::dir_bits($past(port_dir_pull_ctrl_r));
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("pin enable differs from direction bits");

  property p_pull;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> port_pu_en == gsp_pkg::pull_en_bits($past(port_dir_pull_ctrl_r));
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up enable differs from control");

  property p_pull_on_output;
    @(posedge pclk) disable iff (!presetn)
      (port_dir_pull_ctrl_r[0] && !port_dir_pull_ctrl_r[1]) ##1
      (port_dir_pull_ctrl_r[0] && !port_dir_pull_ctrl_r[1]) |-> port_oe[0] && port_pu_en[0];
  endproperty
  a_pull_on_output: assert property (p_pull_on_output) else $error("pull-up dropped on output pin");

  property p_out_data;
    @(posedge pclk) disable iff (!presetn)
      wr_fire && paddr == gsp_pkg::ADDR_LATCH && pstrb[0] ##1 port_dir_pull_ctrl_r[0]
      |=> port_o[0] == $past(pwdata[0], 2);
  endproperty
  a_out_data: assert property (p_out_data) else $error("output pin does not follow latch");

  property p_input_released;
    @(posedge pclk) disable iff (!presetn)
      !port_dir_pull_ctrl_r[2] |=> !port_oe[1];
  endproperty
  a_input_released: assert property (p_input_released) else $error("input pin still driven");

  property p_ctrl_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_fire && paddr == gsp_pkg::ADDR_CTRL) |=> $stable(port_dir_pull_ctrl_r);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

  property p_latch_hold;
    @(posedge pclk) !(wr_fire && paddr == gsp_pkg::ADDR_LATCH) |=> $stable(port_pin_latch_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("data latch changed without write");

  property p_latch_read;
    @(posedge pclk) disable iff (!presetn)
      acc_first && !pwrite && paddr == gsp_pkg::ADDR_LATCH |=> pready && prdata == {24'h00_0000, $past(pin_sample_r)};
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read is not the pin sample");

  property p_ovr_read;
    @(posedge pclk) disable iff (!presetn)
      acc_first && !pwrite && paddr == gsp_pkg::ADDR_OVR
      |=> prdata[31:4] == 28'h000_0000 && prdata[2] == $past(sck_i) && prdata[0] == $past(rxd_i);
  endproperty
  a_ovr_read: assert property (p_ovr_read) else $error("override read wrong");

  property p_sck_drive;
    @(posedge pclk) disable iff (!presetn)
      ovr_sel_r[1] |=> sck_oe && sck_o == $past(ovr_lvl_r[1]);
  endproperty
  a_sck_drive: assert property (p_sck_drive) else $error("clock pin not overridden");

  property p_txd_drive;
    @(posedge pclk) disable iff (!presetn)
      ovr_sel_r[0] |=> txd_oe && txd_o == $past(ovr_lvl_r[0]);
  endproperty
  a_txd_drive: assert property (p_txd_drive) else $error("transmit pin not overridden");

  property p_ovr_sel_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_fire && paddr == gsp_pkg::ADDR_OVR) |=> $stable(ovr_sel_r);
  endproperty
  a_ovr_sel_hold: assert property (p_ovr_sel_hold) else $error("override select changed alone");

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");

  property p_pin_sample;
    @(posedge pclk) disable iff (!presetn)
      bus_clk_en && !bus_release_request |=> pin_sample_r == $past(port_i);
  endproperty
  a_pin_sample: assert property (p_pin_sample) else $error("pin sample missed bus clock");

  property p_sample_frozen;
    @(posedge pclk) disable iff (!presetn)
      bus_release_request |=> $stable(pin_sample_r);
  endproperty
  a_sample_frozen: assert property (p_sample_frozen) else $error("pin sample moved during bus release");

  property p_boot_capture;
    @(posedge pclk) disable iff (!presetn)
      boot_armed_r |=> !boot_armed_r && boot_mode_inputs[2] == $past(rxd_i) &&
        boot_mode_inputs[1] == $past(txd_i) && boot_mode_inputs[0] == $past(sck_i);
  endproperty
  a_boot_capture: assert property (p_boot_capture) else $error("mode pins not captured after reset");

  property p_mode_pins_free;
    @(posedge pclk) disable iff (!presetn)
      !ovr_sel_r[1] && !sci_sck_oe && !ovr_sel_r[0] && !sci_txd_oe |=> !sck_oe && !txd_oe;
  endproperty
  a_mode_pins_free: assert property (p_mode_pins_free) else $error("serial pin driven while unselected");

  property p_ovr_write;
    @(posedge pclk) disable iff (!presetn)
      wr_fire && paddr == gsp_pkg::ADDR_OVR && pstrb[0]
      |=> ovr_sel_r[1] == $past(pwdata[gsp_pkg::OVR_SCLK_SEL]) && ovr_sel_r[0] == $past(pwdata[gsp_pkg::OVR_TXD_SEL]);
  endproperty
  a_ovr_write: assert property (p_ovr_write) else $error("override select not written");

  property p_ctrl_write;
    @(posedge pclk) disable iff (!presetn)
      wr_fire && paddr == gsp_pkg::ADDR_CTRL && pstrb[1:0] == 2'h3
      |=> port_dir_pull_ctrl_r == $past(pwdata[15:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control register not written");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      acc_first && unmapped |=> pready && pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  c_ctrl_write: cover property (@(posedge pclk) wr_fire && paddr == gsp_pkg::ADDR_CTRL);
  c_latch_read: cover property (@(posedge pclk) pready && !pwrite && paddr == gsp_pkg::ADDR_LATCH);
  c_break_send: cover property (@(posedge pclk) txd_oe && ovr_sel_r[0] && !txd_o);
  c_unmapped: cover property (@(posedge pclk) pready && pslverr);
  c_sample_frozen: cover property (@(posedge pclk) bus_release_request && bus_clk_en);

  // manual reset and standby have no effect on any register
  logic unused_resets;
  assign unused_resets = manual_reset_n ^ standby;

endmodule

/* File: testbench/gsp_board_model.sv */
// Purpose: board around the port pins and serial pins
// Assumes: bench chooses external sources; transmit line has a board pull-up
// Notes: an undriven unpulled line wanders every cycle
`timescale 1ns/1ps
module gsp_board_model (
  // clock
  input wire logic pclk,
  // port pins from the device
  input wire logic [7:0] port_o,
  input wire logic [7:0] port_oe,
  input wire logic [7:0] port_pu_en,
  // board sources
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  input wire logic ext_sck,
  input wire logic ext_rxd,
  // serial pins from the device
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic txd_o,
  input wire logic txd_oe,
  // levels seen at the pins
  output logic [7:0] port_i,
  output logic sck_i,
  output logic txd_i,
  output logic rxd_i
);
  logic flt = 1'b0;
  always @(posedge pclk) begin
    flt <= ~flt;
  end
  // ==========================================================
  // pin resolution: driver beats board, pull-up is weakest
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (port_oe[n]) begin
        port_i[n] = port_o[n];
      end else if (ext_drv[n]) begin
        port_i[n] = ext_val[n];
      end else if (port_pu_en[n]) begin
        port_i[n] = 1'b1;
      end else begin
        port_i[n] = flt;
      end
    end
  end
  assign sck_i = sck_oe ? sck_o : ext_sck;
  assign txd_i = txd_oe ? txd_o : 1'b1;
  assign rxd_i = ext_rxd;
endmodule

/* File: testbench/gpio_and_serial_pin_port_tb.sv */
// Purpose: self-checking bench of the port and serial pin override block
// Assumes: apb slave answers on its own; board modelled beside it
// Notes: random traffic from a fixed seed plus corner cases
`timescale 1ns/1ps
module gpio_and_serial_pin_port_tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, manual_reset_n, standby, bus_release_request;
  logic [7:0] paddr, port_i, port_o, port_oe, port_pu_en, ext_val, ext_drv, l, e;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0] pstrb;
  logic [15:0] c;
  logic [2:0] boot_mode_inputs;
  logic sck_i, txd_i, rxd_i, sck_o, sck_oe, txd_o, txd_oe, ext_sck, ext_rxd, err;
  logic sci_sck_o, sci_sck_oe, sci_txd_o, sci_txd_oe, es, et;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 36;
  always #12.5 pclk = ~pclk;
  gsp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .manual_reset_n(manual_reset_n), .standby(standby), .bus_release_request(bus_release_request),
    .port_i(port_i), .port_o(port_o), .port_oe(port_oe), .port_pu_en(port_pu_en), .sck_i(sck_i),
    .txd_i(txd_i), .rxd_i(rxd_i), .sck_o(sck_o), .sck_oe(sck_oe), .txd_o(txd_o), .txd_oe(txd_oe),
    .sci_sck_o(sci_sck_o), .sci_sck_oe(sci_sck_oe), .sci_txd_o(sci_txd_o), .sci_txd_oe(sci_txd_oe),
    .boot_mode_inputs(boot_mode_inputs));
  gsp_board_model board (.pclk(pclk), .port_o(port_o), .port_oe(port_oe), .port_pu_en(port_pu_en),
    .ext_val(ext_val), .ext_drv(ext_drv), .ext_sck(ext_sck), .ext_rxd(ext_rxd), .sck_o(sck_o),
    .sck_oe(sck_oe), .txd_o(txd_o), .txd_oe(txd_oe), .port_i(port_i), .sck_i(sck_i), .txd_i(txd_i),
    .rxd_i(rxd_i));
  // ==========================================================
  // expectations
  function automatic logic [7:0] f_dir(input logic [15:0] v);
    for (int n = 0; n < 8; n++) begin
      f_dir[n] = v[2*n];
    end
  endfunction
  function automatic logic [7:0] f_pu(input logic [15:0] v);
    for (int n = 0; n < 8; n++) begin
      f_pu[n] = ~v[2*n+1];
    end
  endfunction
  // ==========================================================
  // checks and bus cycles
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_rd({24'h0, got}, {24'h0, exp});
  endtask
  // entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? 4'hf : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #(25 * 5000);
    num_errors++;
    tally_and_finish();
  end
  // ==========================================================
  // tests
  initial begin
    {presetn, psel, penable, pwrite, standby, sci_sck_o, sci_sck_oe, sci_txd_o, sci_txd_oe} = 9'h0;
    bus_release_request = 1'b0;
    manual_reset_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ext_val = 8'h00;
    ext_drv = 8'hff;
    ext_sck = 1'b1;
    ext_rxd = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_pin(port_oe, 8'h00);
    chk_pin(port_pu_en, 8'hff);
    chk_pin({5'h0, boot_mode_inputs}, {5'h0, ext_rxd, 1'b1, ext_sck});
    apb(1'b0, gsp_pkg::ADDR_CTRL, 32'h0);
    chk_rd(rd, 32'h0);
    apb(1'b0, gsp_pkg::ADDR_OVR, 32'h0);
    chk_rd(rd, {29'h0, ext_sck, 2'h0});
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      l = r[7:0];
      e = r[15:8];
      c = (i == 0) ? 16'h5555 : (i == 1) ? 16'haaaa : r[31:16];
      apb(1'b1, gsp_pkg::ADDR_LATCH, {24'h0, l});
      apb(1'b1, gsp_pkg::ADDR_CTRL, {16'h0, c});
      ext_val <= e;
      repeat (10) @(posedge pclk);
      chk_pin(port_oe, f_dir(c));
      chk_pin(port_o, l & f_dir(c));
      chk_pin(port_pu_en, f_pu(c));
      apb(1'b0, gsp_pkg::ADDR_LATCH, 32'h0);
      chk_rd(rd, {24'h0, (l & f_dir(c)) | (e & ~f_dir(c))});
      apb(1'b0, gsp_pkg::ADDR_CTRL, 32'h0);
      chk_rd(rd, {16'h0, c});
    end
    $display("test random port done");
    ext_drv <= 8'h00;
    apb(1'b1, gsp_pkg::ADDR_CTRL, 32'h0);
    repeat (10) @(posedge pclk);
    apb(1'b0, gsp_pkg::ADDR_LATCH, 32'h0);
    chk_rd(rd, 32'hff);
    ext_drv <= 8'hff;
    bus_release_request <= 1'b1;
    ext_val <= 8'h96;
    repeat (10) @(posedge pclk);
    bus_release_request <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, gsp_pkg::ADDR_LATCH, 32'h0);
    chk_rd(rd, 32'h96);
    $display("test pull-up and release done");
    apb(1'b1, gsp_pkg::ADDR_LATCH, 32'h3c);
    apb(1'b1, gsp_pkg::ADDR_CTRL, 32'hffff);
    apb(1'b1, gsp_pkg::ADDR_OVR, 32'h0a);
    manual_reset_n <= 1'b0;
    standby <= 1'b1;
    repeat (5) @(posedge pclk);
    manual_reset_n <= 1'b1;
    standby <= 1'b0;
    apb(1'b0, gsp_pkg::ADDR_CTRL, 32'h0);
    chk_rd(rd, 32'hffff);
    apb(1'b0, gsp_pkg::ADDR_OVR, 32'h0);
    chk_rd(rd & 32'hfa, 32'h0a);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, gsp_pkg::ADDR_CTRL, 32'h0);
    chk_rd(rd, 32'h0);
    apb(1'b0, gsp_pkg::ADDR_OVR, 32'h0);
    chk_rd(rd & 32'hfa, 32'h0);
    apb(1'b1, gsp_pkg::ADDR_CTRL, 32'hffff);
    repeat (3) @(posedge pclk);
    chk_pin(port_o, 8'h3c);
    $display("test retention done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      sci_sck_o <= r[4];
      sci_txd_o <= r[5];
      sci_sck_oe <= r[6] & ~i[3];
      sci_txd_oe <= r[7] & ~i[1];
      ext_sck <= r[8];
      ext_rxd <= r[9];
      apb(1'b1, gsp_pkg::ADDR_OVR, {24'h0, 4'h0, i[3:0]});
      repeat (3) @(posedge pclk);
      es = i[3] ? i[2] : (r[6] ? r[4] : r[8]);
      et = i[1] ? i[0] : r[5];
      chk_pin({4'h0, sck_oe, sck_o, txd_oe, txd_o},
        {4'h0, i[3] | r[6], i[3] ? i[2] : r[4], i[1] | r[7], et});
      apb(1'b0, gsp_pkg::ADDR_OVR, 32'h0);
      chk_rd(rd, {28'h0, i[3], es, i[1], r[9]});
    end
    $display("test serial override done");
    apb(1'b1, 8'h0c, 32'h55);
    chk_pin({7'h0, err}, 8'h01);
    apb(1'b0, 8'h0c, 32'h0);
    chk_rd(rd, 32'h0);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
